// file: inc/spi_ctl_pkg.sv
`default_nettype none
package spi_ctl_pkg;

	// ------------------------------------------------------------
	// Register addresses
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL = 8'hf8;
	localparam logic [7:0] ADDR_CFG = 8'ha1;
	localparam logic [7:0] ADDR_RATE = 8'ha2;
	localparam logic [7:0] ADDR_DATA = 8'ha3;

	// ------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------
	localparam int CTL_DONE = 7;
	localparam int CTL_WRITE_COLLISION_FLAG = 6;
	localparam int CTL_MODE_FAULT_FLAG = 5;
	localparam int CTL_OVR = 4;
	localparam int CTL_SELH = 3;
	localparam int CTL_SELL = 2;
	localparam int CTL_TXE = 1;
	localparam int CTL_EN = 0;
	localparam int CFG_MASTER = 6;
	localparam int CFG_PHASE = 5;
	localparam int CFG_POL = 4;
	localparam logic [7:0] CTRL_RESET = 8'h06;
	localparam logic [7:0] CFG_RESET = 8'h07;
	localparam logic [7:0] RATE_RESET = 8'h00;

	// ------------------------------------------------------------
	// Modes and counts
	// ------------------------------------------------------------
	localparam logic [1:0] SELECT_3WIRE = 2'h0;
	localparam logic [1:0] SELECT_4IN = 2'h1;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam logic [3:0] HALF_LAST = 4'hf;

	typedef enum logic {
		M_IDLE = 1'b0,
		M_RUN = 1'b1
	} master_state_e;

	typedef struct packed {
		logic sck;
		logic mosi;
		logic miso;
		logic nss;
	} spi_pins_in_s;

	localparam logic [3:0] PINS_IN_RESET = 4'h1;

	typedef struct packed {
		logic sck;
		logic sck_oe_n;
		logic mosi;
		logic mosi_oe_n;
		logic miso;
		logic miso_oe_n;
		logic nss;
		logic nss_oe_n;
	} spi_pins_out_s;

endpackage
`default_nettype wire

// file: hw/spi_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module spi_pin_sync #(
	parameter int WIDTH = 4,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
	// Clock and reset.
	input wire logic clk_in,
	input wire logic rst_in,
	// Asynchronous levels and their synchronised copies.
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] stage_one;

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			stage_one <= RESET_VALUE;
			sync_out <= RESET_VALUE;
		end else begin
			stage_one <= async_in;
			sync_out <= stage_one;
		end
	end

endmodule
`default_nettype wire

// file: hw/spi_control_status.sv
// Summary of operation
// - Master bus collision sets sticky mode fault.
// - Slave byte into full buffer sets overrun.
// - Overrun raises interrupt, cleared only by software.
// - Writing transmit buffer clears buffer empty.
// - Buffer moving to shifter sets empty again.
// - Control, data, configuration, rate reachable as registers.
`timescale 1ns/1ps
`default_nettype none
module spi_control_status
	import spi_ctl_pkg::*;
(
	// Clock and reset.
	input wire logic clk_in,
	input wire logic rst_in,
	// Special function register port.
	input wire logic [7:0] sfr_addr_in,
	input wire logic sfr_wr_in,
	input wire logic [7:0] sfr_wdata_in,
	input wire logic sfr_bit_wr_in,
	input wire logic [2:0] sfr_bit_idx_in,
	input wire logic sfr_bit_val_in,
	input wire logic sfr_rd_in,
	output logic [7:0] sfr_rdata_out,
	output logic irq_out,
	// Serial pins.
	input wire spi_pins_in_s pins_in,
	output var spi_pins_out_s pins_out
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	spi_pins_in_s pins_s;
	logic done_flag, write_collision_flag_flag, mode_fault_flag_flag, ovr_flag, txe, port_enable;
	logic [1:0] select_mode;
	logic master_en, phase, pol;
	logic [7:0] rate, tx_buf, rx_buf, tx_shift, rx_shift, div_cnt;
	logic rx_empty, busy, sh_full, out_bit, sck_d;
	logic [2:0] bit_cnt;
	logic [3:0] half_cnt;
	master_state_e state;
	logic sck_reg, sck_oe_n, mosi_oe_n, miso_oe_n, nss_reg, nss_oe_n;
	logic [7:0] ctl_mask, ctl_val;
	logic data_wr, data_rd, cfg_wr, rate_wr, master_ok, slave_sel, mode_fault_flag_cond;
	logic leading, trailing, tick, sample_evt, shift_evt, rx_bit;
	logic slave_done, master_done, byte_done, load_evt, rx_empty_eff, abort;
	logic [7:0] rx_byte;

	spi_pin_sync #(
		.WIDTH(4),
		.RESET_VALUE(PINS_IN_RESET)
	) pin_sync (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.async_in(pins_in),
		.sync_out(pins_s)
	);

	function automatic logic flag_next(input logic set, input logic m, input logic v,
		input logic cur);
		flag_next = set | (m ? v : cur);
	endfunction

	// ------------------------------------------------------------
	// Register access decode
	// ------------------------------------------------------------
	always_comb begin
		ctl_mask = 8'h00;
		ctl_val = 8'h00;
		if (sfr_wr_in && sfr_addr_in == ADDR_CTRL) begin
			ctl_mask = 8'hff;
			ctl_val = sfr_wdata_in;
		end else if (sfr_bit_wr_in) begin
			ctl_mask = 8'h01 << sfr_bit_idx_in;
			ctl_val = {8{sfr_bit_val_in}};
		end
	end

	assign data_wr = sfr_wr_in && sfr_addr_in == ADDR_DATA;
	assign data_rd = sfr_rd_in && sfr_addr_in == ADDR_DATA;
	assign cfg_wr = sfr_wr_in && sfr_addr_in == ADDR_CFG;
	assign rate_wr = sfr_wr_in && sfr_addr_in == ADDR_RATE;

	// ------------------------------------------------------------
	// Bit events
	// ------------------------------------------------------------
	assign master_ok = master_en && port_enable;
	assign slave_sel = port_enable && !master_en &&
		(select_mode == SELECT_3WIRE || !pins_s.nss);
	assign mode_fault_flag_cond = master_ok && select_mode == SELECT_4IN && !pins_s.nss;
	assign tick = state == M_RUN && div_cnt == rate;
	assign leading = (slave_sel && pins_s.sck != sck_d && sck_d == pol) ||
		(tick && !half_cnt[0]);
	assign trailing = (slave_sel && pins_s.sck != sck_d && sck_d != pol) ||
		(tick && half_cnt[0]);
	assign sample_evt = phase ? trailing : leading;
	assign shift_evt = phase ? leading : trailing;
	assign rx_bit = master_en ? pins_s.miso : pins_s.mosi;
	assign slave_done = slave_sel && sample_evt && bit_cnt == BIT_LAST;
	assign master_done = tick && half_cnt == HALF_LAST;
	assign byte_done = slave_done || master_done;
	assign rx_byte = slave_done ? {rx_shift[6:0], rx_bit} : rx_shift;
	assign rx_empty_eff = rx_empty || data_rd;
	assign load_evt = port_enable && !txe && !sh_full && !busy && !sample_evt && !shift_evt;
	assign abort = state == M_IDLE && !slave_sel;

	// ------------------------------------------------------------
	// Control and status flags
	// ------------------------------------------------------------
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			{done_flag, write_collision_flag_flag, mode_fault_flag_flag, ovr_flag} <= CTRL_RESET[CTL_DONE:CTL_OVR];
			select_mode <= CTRL_RESET[CTL_SELH:CTL_SELL];
			port_enable <= CTRL_RESET[CTL_EN];
		end else begin
			done_flag <= flag_next(byte_done, ctl_mask[CTL_DONE], ctl_val[CTL_DONE],
				done_flag);
			write_collision_flag_flag <= flag_next(data_wr && !txe, ctl_mask[CTL_WRITE_COLLISION_FLAG], ctl_val[CTL_WRITE_COLLISION_FLAG],
				write_collision_flag_flag);
			mode_fault_flag_flag <= flag_next(mode_fault_flag_cond, ctl_mask[CTL_MODE_FAULT_FLAG], ctl_val[CTL_MODE_FAULT_FLAG],
				mode_fault_flag_flag);
			ovr_flag <= flag_next(byte_done && !master_en && !rx_empty_eff,
				ctl_mask[CTL_OVR], ctl_val[CTL_OVR], ovr_flag);
			if (ctl_mask[CTL_SELH]) begin
				select_mode[1] <= ctl_val[CTL_SELH];
			end
			if (ctl_mask[CTL_SELL]) begin
				select_mode[0] <= ctl_val[CTL_SELL];
			end
			if (ctl_mask[CTL_EN]) begin
				port_enable <= ctl_val[CTL_EN];
			end
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			master_en <= CFG_RESET[CFG_MASTER];
			phase <= CFG_RESET[CFG_PHASE];
			pol <= CFG_RESET[CFG_POL];
			rate <= RATE_RESET;
		end else begin
			if (cfg_wr) begin
				master_en <= sfr_wdata_in[CFG_MASTER];
				phase <= sfr_wdata_in[CFG_PHASE];
				pol <= sfr_wdata_in[CFG_POL];
			end
			if (rate_wr) begin
				rate <= sfr_wdata_in;
			end
		end
	end

	// ------------------------------------------------------------
	// Transmit and receive buffers
	// ------------------------------------------------------------
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			txe <= CTRL_RESET[CTL_TXE];
			tx_buf <= 8'h00;
		end else if (data_wr && txe) begin
			tx_buf <= sfr_wdata_in;
			txe <= 1'b0;
		end else if (load_evt) begin
			txe <= 1'b1;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			rx_buf <= 8'h00;
			rx_empty <= CFG_RESET[0];
		end else if (byte_done && (master_en || rx_empty_eff)) begin
			rx_buf <= rx_byte;
			rx_empty <= 1'b0;
		end else if (data_rd) begin
			rx_empty <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Shift engine
	// ------------------------------------------------------------
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			tx_shift <= 8'h00;
			rx_shift <= 8'h00;
			out_bit <= 1'b0;
			sh_full <= 1'b0;
			busy <= 1'b0;
			bit_cnt <= 3'h0;
			sck_d <= 1'b0;
		end else begin
			sck_d <= pins_s.sck;
			if (load_evt) begin
				sh_full <= 1'b1;
				tx_shift <= phase ? tx_buf : {tx_buf[6:0], 1'b0};
				if (!phase) begin
					out_bit <= tx_buf[7];
				end
			end else if (shift_evt) begin
				out_bit <= tx_shift[7];
				tx_shift <= {tx_shift[6:0], 1'b0};
			end
			if (sample_evt) begin
				rx_shift <= {rx_shift[6:0], rx_bit};
				bit_cnt <= bit_cnt + 3'h1;
			end
			if (byte_done) begin
				busy <= 1'b0;
				sh_full <= 1'b0;
				bit_cnt <= 3'h0;
			end else if (abort) begin
				busy <= 1'b0;
				bit_cnt <= 3'h0;
			end else if (leading || (state == M_IDLE && master_ok && sh_full)) begin
				busy <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// Master clock generator
	// ------------------------------------------------------------
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			state <= M_IDLE;
			div_cnt <= 8'h00;
			half_cnt <= 4'h0;
			sck_reg <= 1'b0;
		end else if (mode_fault_flag_cond || !master_ok) begin
			state <= M_IDLE;
			div_cnt <= 8'h00;
			half_cnt <= 4'h0;
			sck_reg <= pol;
		end else begin
			case (state)
				M_IDLE: begin
					sck_reg <= pol;
					div_cnt <= 8'h00;
					half_cnt <= 4'h0;
					if (sh_full) begin
						state <= M_RUN;
					end
				end
				M_RUN: begin
					if (tick) begin
						div_cnt <= 8'h00;
						sck_reg <= !sck_reg;
						half_cnt <= half_cnt + 4'h1;
						if (half_cnt == HALF_LAST) begin
							state <= M_IDLE;
						end
					end else begin
						div_cnt <= div_cnt + 8'h01;
					end
				end
				default: begin
					state <= M_IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Pin drivers, read data and interrupt
	// ------------------------------------------------------------
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			{sck_oe_n, mosi_oe_n, miso_oe_n, nss_oe_n} <= 4'hf;
			nss_reg <= 1'b1;
			irq_out <= 1'b0;
		end else begin
			sck_oe_n <= !master_ok;
			mosi_oe_n <= !master_ok;
			miso_oe_n <= !slave_sel;
			nss_oe_n <= !(port_enable && select_mode[1]);
			nss_reg <= select_mode[0];
			irq_out <= done_flag || ovr_flag;
		end
	end

	assign pins_out = '{sck: sck_reg, sck_oe_n: sck_oe_n, mosi: out_bit,
		mosi_oe_n: mosi_oe_n, miso: out_bit, miso_oe_n: miso_oe_n,
		nss: nss_reg, nss_oe_n: nss_oe_n};

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			sfr_rdata_out <= 8'h00;
		end else if (sfr_rd_in) begin
			case (sfr_addr_in)
				ADDR_CTRL: sfr_rdata_out <= {done_flag, write_collision_flag_flag, mode_fault_flag_flag, ovr_flag,
					select_mode, txe, port_enable};
				ADDR_CFG: sfr_rdata_out <= {busy, master_en, phase, pol, !pins_s.nss,
					pins_s.nss, !busy && txe, rx_empty};
				ADDR_RATE: sfr_rdata_out <= rate;
				ADDR_DATA: sfr_rdata_out <= rx_buf;
				default: sfr_rdata_out <= 8'h00;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	AST_MODE_FAULT_FLAG_SET: assert property (@(posedge clk_in) disable iff (rst_in)
		mode_fault_flag_cond |=> mode_fault_flag_flag) else $error("Mode fault flag not set.");
	AST_OVR_SET: assert property (@(posedge clk_in) disable iff (rst_in)
		byte_done && !master_en && !rx_empty_eff |=> ovr_flag && $stable(rx_buf))
		else $error("Overrun not flagged or buffer overwritten.");
	AST_OVR_IRQ: assert property (@(posedge clk_in) disable iff (rst_in)
		$rose(ovr_flag) |=> irq_out) else $error("Overrun gave no interrupt.");
	AST_OVR_STICKY: assert property (@(posedge clk_in) disable iff (rst_in)
		ovr_flag && !(ctl_mask[CTL_OVR] && !ctl_val[CTL_OVR]) |=> ovr_flag)
		else $error("Overrun cleared without software.");
	AST_TXE_CLEAR: assert property (@(posedge clk_in) disable iff (rst_in)
		data_wr && txe |=> !txe && tx_buf == $past(sfr_wdata_in))
		else $error("Buffer write did not clear empty.");
	AST_TXE_SET: assert property (@(posedge clk_in) disable iff (rst_in)
		load_evt |=> txe && sh_full) else $error("Load did not set empty.");
	AST_CTRL_READ: assert property (@(posedge clk_in) disable iff (rst_in)
		sfr_rd_in && sfr_addr_in == ADDR_CTRL |=> sfr_rdata_out[CTL_TXE] == $past(txe))
		else $error("Control read shows wrong empty bit.");
	AST_DONE_SET: assert property (@(posedge clk_in) disable iff (rst_in)
		byte_done |=> done_flag ##1 irq_out) else $error("Byte end not flagged.");

endmodule
`default_nettype wire

// file: verification/spi_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module spi_master_model (
	// Serial lines driven toward the port.
	output logic sck_out,
	output logic mosi_out,
	output logic nss_n_out,
	// Serial line driven back by the port.
	input wire logic miso_in
);
	logic [7:0] last_rx;

	// --------------------------------
	// Frame control
	// --------------------------------
	initial begin
		sck_out = 1'b0;
		mosi_out = 1'b0;
		nss_n_out = 1'b1;
		last_rx = 8'h00;
	end

	// Drives the select line to the given level, clear of the clock edge.
	task automatic select(input logic v);
		#1 nss_n_out = v;
	endtask

	// Sends one byte msb first and keeps what the port returns on its sampling edges.
	// The clock idles low, and select stays high for a while after each frame.
	task automatic send(input logic [7:0] b);
		nss_n_out = 1'b0;
		#250;
		for (int i = 7; i >= 0; i--) begin
			mosi_out = b[i];
			#62.5 sck_out = 1'b1;
			last_rx = {last_rx[6:0], miso_in};
			#62.5 sck_out = 1'b0;
		end
		#250 nss_n_out = 1'b1;
		mosi_out = ~mosi_out;
		#250;
	endtask
endmodule
`default_nettype wire

// file: verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
	$display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top
	import spi_ctl_pkg::*;
;
	// --------------------------------
	// Stimulus and wiring
	// --------------------------------
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic [7:0] sfr_addr_in = 8'h00;
	logic sfr_wr_in = 1'b0;
	logic [7:0] sfr_wdata_in = 8'h00;
	logic sfr_bit_wr_in = 1'b0;
	logic [2:0] sfr_bit_idx_in = 3'h0;
	logic sfr_bit_val_in = 1'b0;
	logic sfr_rd_in = 1'b0;
	logic [7:0] sfr_rdata_out;
	logic irq_out;
	logic m_sck;
	logic m_mosi;
	logic m_nss_n;
	int n_errors = 0;
	int comparisons = 0;
	spi_pins_in_s pins_in;
	spi_pins_out_s pins_out;
	logic [7:0] mosi_cap = 8'h00;
	logic [7:0] n_sck = 8'h00;

	always #4 clk_in = ~clk_in;

	// Collects the bits the port sends as master on each rising serial clock.
	always @(posedge pins_out.sck) begin
		mosi_cap <= {mosi_cap[6:0], pins_out.mosi};
		n_sck <= n_sck + 8'h01;
	end

	// Each wire follows whichever party drives it; miso, when the port does not drive it, reads the inverse of the port's own miso bit.
	assign pins_in = {pins_out.sck_oe_n ? m_sck : pins_out.sck,
		pins_out.mosi_oe_n ? m_mosi : pins_out.mosi,
		pins_out.miso_oe_n ? ~pins_out.miso : pins_out.miso,
		pins_out.nss_oe_n ? m_nss_n : pins_out.nss};

	spi_control_status u_dut (.clk_in(clk_in), .rst_in(rst_in), .sfr_addr_in(sfr_addr_in),
		.sfr_wr_in(sfr_wr_in), .sfr_wdata_in(sfr_wdata_in), .sfr_bit_wr_in(sfr_bit_wr_in),
		.sfr_bit_idx_in(sfr_bit_idx_in), .sfr_bit_val_in(sfr_bit_val_in),
		.sfr_rd_in(sfr_rd_in), .sfr_rdata_out(sfr_rdata_out), .irq_out(irq_out),
		.pins_in(pins_in), .pins_out(pins_out));

	spi_master_model u_master (.sck_out(m_sck), .mosi_out(m_mosi), .nss_n_out(m_nss_n),
		.miso_in(pins_in.miso));

	// --------------------------------
	// Register access
	// --------------------------------
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		sfr_addr_in <= a;
		sfr_wdata_in <= d;
		sfr_wr_in <= 1'b1;
		@(posedge clk_in);
		sfr_wr_in <= 1'b0;
	endtask

	task automatic bwr(input logic [2:0] i, input logic v);
		@(posedge clk_in);
		sfr_bit_idx_in <= i;
		sfr_bit_val_in <= v;
		sfr_bit_wr_in <= 1'b1;
		@(posedge clk_in);
		sfr_bit_wr_in <= 1'b0;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_in);
		sfr_addr_in <= a;
		sfr_rd_in <= 1'b1;
		@(posedge clk_in);
		sfr_rd_in <= 1'b0;
		#1;
		`CHK(sfr_rdata_out, e)
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask

	task automatic conclude();
		$display("errors=%0d comparisons=%0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// --------------------------------
	// Tests
	// --------------------------------
	initial begin
		#200000;
		n_errors++;
		conclude();
	end

	initial begin
		repeat (2) @(posedge clk_in);
		rst_in <= 1'b0;
		rchk(ADDR_CTRL, 8'h06);
		rchk(ADDR_CFG, 8'h07);
		rchk(ADDR_RATE, 8'h00);
		rchk(8'h55, 8'h00);
		wr(ADDR_RATE, 8'h5a);
		wr(8'h55, 8'hff);
		rchk(ADDR_RATE, 8'h5a);
		$display("test registers done");
		wr(ADDR_DATA, 8'h3c);
		rchk(ADDR_CTRL, 8'h04);
		wr(ADDR_DATA, 8'h11);
		rchk(ADDR_CTRL, 8'h44);
		bwr(3'h6, 1'b0);
		wr(ADDR_CTRL, 8'h05);
		rchk(ADDR_CTRL, 8'h07);
		$display("test transmit empty done");
		u_master.send(8'ha5);
		`CHK(u_master.last_rx, 8'h3c)
		idle(8);
		rchk(ADDR_CTRL, 8'h87);
		`CHK(irq_out, 1'b1)
		rchk(ADDR_DATA, 8'ha5);
		bwr(3'h7, 1'b0);
		u_master.send(8'h5b);
		u_master.send(8'hc3);
		idle(8);
		rchk(ADDR_CTRL, 8'h97);
		rchk(ADDR_DATA, 8'h5b);
		bwr(3'h7, 1'b0);
		idle(3);
		`CHK(irq_out, 1'b1)
		rchk(ADDR_CTRL, 8'h17);
		bwr(3'h4, 1'b0);
		idle(3);
		`CHK(irq_out, 1'b0)
		$display("test slave done");
		wr(ADDR_CFG, 8'h40);
		wr(ADDR_RATE, 8'h00);
		wr(ADDR_CTRL, 8'h0d);
		wr(ADDR_DATA, 8'h96);
		idle(60);
		rchk(ADDR_CTRL, 8'h8f);
		`CHK(mosi_cap, 8'h96)
		`CHK(n_sck, 8'h08)
		$display("test master done");
		wr(ADDR_CTRL, 8'h05);
		u_master.select(1'b0);
		idle(6);
		rchk(ADDR_CTRL, 8'h27);
		u_master.select(1'b1);
		idle(6);
		rchk(ADDR_CTRL, 8'h27);
		bwr(3'h5, 1'b0);
		rchk(ADDR_CTRL, 8'h07);
		$display("test mode fault done");
		conclude();
	end
endmodule
`default_nettype wire
